// *** scw_host_model.sv ***
// Host controller model: serial clock, data and load
`timescale 1ns/1ps
`default_nettype none
module scw_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic serial_clk,
    output logic serial_data,
    output logic serial_load
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        serial_load = 1'b0;
    end
    // Clock stands low between frames; data shows the inverse once released
    task automatic send(input logic [29:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data <= w[i];
            serial_clk <= 1'b0;
            repeat (8) @(posedge clock);
            serial_clk <= 1'b1;
            repeat (8) @(posedge clock);
        end
        serial_clk <= 1'b0;
        serial_data <= ~w[0];
        repeat (8) @(posedge clock);
        serial_load <= 1'b1;
        repeat (8) @(posedge clock);
        serial_load <= 1'b0;
        repeat (12) @(posedge clock);
    endtask : send
endmodule : scw_host_model
`default_nettype wire

// *** scw_pkg.sv ***
// Package: constants for the serial configuration write port
package scw_pkg;
    // ----------------------------------------
    // Word layout
    // ----------------------------------------
    localparam int WORD_BITS = 26;
    localparam int DATA_BITS = 24;
    localparam int SEL_BITS = 2;
    // ----------------------------------------
    // Register select codes
    // ----------------------------------------
    localparam logic [1:0] SEL_DAC_MIXER_LO_WORD = 2'h0;
    localparam logic [1:0] SEL_DIVIDER_PUMP_CAL_MUTE_WORD = 2'h1;
    localparam logic [1:0] SEL_MODE_COUNTER_WORD = 2'h2;
    localparam logic [1:0] SEL_RESERVED_WORD = 2'h3;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [23:0] DAC_MIXER_LO_WORD_RST = 24'h000000;
    localparam logic [23:0] DIVIDER_PUMP_CAL_MUTE_WORD_RST = 24'h000000;
    localparam logic [23:0] MODE_COUNTER_WORD_RST = 24'h000000;
    // ----------------------------------------
    // Field positions, first word
    // ----------------------------------------
    localparam int W1_DAC_HI = 23;
    localparam int W1_DAC_LO = 14;
    localparam int W1_BIAS_HI = 13;
    localparam int W1_BIAS_LO = 10;
    localparam int W1_DAC_OFF = 9;
    localparam int W1_RETUNE_EN = 8;
    localparam int W1_AMP_HI = 7;
    localparam int W1_AMP_LO = 6;
    localparam int W1_TRIM_HI = 5;
    localparam int W1_TRIM_LO = 3;
    localparam int W1_LO_LEVEL_HI = 2;
    localparam int W1_LO_LEVEL_LO = 1;
    localparam int W1_MUX_TEST = 0;
    // ----------------------------------------
    // Field positions, second word
    // ----------------------------------------
    localparam int W2_REFDIV_HI = 23;
    localparam int W2_REFDIV_LO = 14;
    localparam int W2_SWING_HI = 13;
    localparam int W2_SWING_LO = 12;
    localparam int W2_PUMP_HI = 11;
    localparam int W2_PUMP_LO = 9;
    localparam int W2_PRESCALER = 8;
    localparam int W2_ALGORITHM = 7;
    localparam int W2_KICKOFF = 6;
    localparam int W2_EXT_TEST = 5;
    localparam int W2_MUTE_EN = 4;
    localparam int W2_MUTE_TYPE = 3;
    localparam int W2_MUTE_LO = 2;
    localparam int W2_MUTE_MIX = 1;
    localparam int W2_MUTE_AMP = 0;
    // ----------------------------------------
    // Field positions, third word
    // ----------------------------------------
    localparam int W3_LEVEL_LOOP_OFF = 23;
    localparam int W3_PEAK_TEST = 22;
    localparam int W3_FUNC_HI = 21;
    localparam int W3_FUNC_LO = 17;
    localparam int W3_B_HI = 16;
    localparam int W3_B_LO = 5;
    localparam int W3_A_HI = 4;
    localparam int W3_A_LO = 0;
    // ----------------------------------------
    // Functional modes and prescaler
    // ----------------------------------------
    localparam logic [4:0] FUNC_POWER_DOWN = 5'h00;
    localparam int PRESCALER_LOW = 16;
    localparam int PRESCALER_HIGH = 19;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SCLK_MAX_MHZ = 100;
    localparam int SYNC_STAGES = 3;
endpackage : scw_pkg

// *** scw_port.sv ***
// Serial configuration write port: shift register, load decode, config words
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Write-only port, no readback; serial clock up to 100 MHz; at a 100 MHz clock the two-clock hold limits the port to 25 MHz.
// - Each transfer is 26 bits; the last 26 bits shifted form the word.
// - Sent MSB first; top two bits select register, lower 24 are data.
// - Data bit captured into the shift register on serial clock rising edge.
// - Load rising edge copies the shift word into the selected register.
// - Select 00 first word, 01 second, 10 third, 11 reserved.
// - First word holds DAC, bias, DAC off, retune enable, amp, trim, LO level.
// - Prescaler modulus bit: 0 gives 16, 1 gives 19.
// - Second word holds divider, swing, pump, prescaler, tuning and mute controls.
// - Tuning algorithm bit picks standard or enhanced VCO calibration.
// - Kickoff bit starts calibration and clears itself when calibration ends.
// - Third word holds function select, B counter and A counter.
// - After power-up the device sits in power-down mode until programmed.
// - With retune enable set, loss of lock restarts calibration automatically; the code skips the relaunch while kickoff is still set.
//
module scw_port
    import scw_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Serial pins
    input wire logic host_bus_select,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic serial_load,
    // Calibration engine status
    input wire logic cal_done,
    input wire logic pll_locked,
    // Register contents
    output logic [DATA_BITS-1:0] dac_mixer_lo_word,
    output logic [DATA_BITS-1:0] divider_pump_cal_mute_word,
    output logic [DATA_BITS-1:0] mode_counter_word,
    // Decoded controls
    output logic [4:0] function_select,
    output logic retune_on_unlock_enable,
    output logic [4:0] prescaler_modulus_value,
    output logic tuning_algorithm,
    output logic tuning_kickoff,
    output logic cal_start,
    output logic word_loaded
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic sclk_s;
    logic sdat_s;
    logic load_s;
    logic sel_s;

    // Host pins are asynchronous; stage agreement filters glitches
    scw_sync u_sync_clk (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(serial_clk),
        .level(sclk_s)
    );

    scw_sync u_sync_dat (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(serial_data),
        .level(sdat_s)
    );

    scw_sync u_sync_load (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(serial_load),
        .level(load_s)
    );

    scw_sync u_sync_sel (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .pin(host_bus_select),
        .level(sel_s)
    );

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic sclk_q;
    logic load_q;
    logic locked_q;
    // Data passes the same depth as the clock, so it is sampled as it stood at the edge
    wire sclk_rise = sclk_s & ~sclk_q;
    wire load_rise = load_s & ~load_q;
    // Lock status already runs on this clock, so it skips the synchroniser
    wire lock_fall = locked_q & ~pll_locked;
    // Host must hold each pin level for two clocks or the edge is lost
    // Port ignores the pins while the two-wire bus is chosen
    wire port_on = sel_s;

    // ----------------------------------------
    // Shift register
    // ----------------------------------------
    logic [WORD_BITS-1:0] shift_q;
    wire [WORD_BITS-1:0] shift_d = {shift_q[WORD_BITS-2:0], sdat_s};
    wire [SEL_BITS-1:0] sel = shift_q[WORD_BITS-1 -: SEL_BITS];
    wire [DATA_BITS-1:0] payload = shift_q[DATA_BITS-1:0];
    // Any number of bits may be shifted; only the last 26 reach a word
    wire shift_en = port_on & sclk_rise;

    // ----------------------------------------
    // Load decode
    // ----------------------------------------
    wire do_load = port_on & load_rise;
    wire ld_w1 = do_load & (sel == SEL_DAC_MIXER_LO_WORD);
    wire ld_w2 = do_load & (sel == SEL_DIVIDER_PUMP_CAL_MUTE_WORD);
    wire ld_w3 = do_load & (sel == SEL_MODE_COUNTER_WORD);
    // Reserved select loads nothing; no readback path exists at all
    wire ld_any = ld_w1 | ld_w2 | ld_w3;

    // ----------------------------------------
    // Config registers
    // ----------------------------------------
    logic [DATA_BITS-1:0] w1_q;
    logic [DATA_BITS-1:0] w2_q;
    logic [DATA_BITS-1:0] w3_q;
    logic start_q;
    logic loaded_q;
    // Kickoff write launches calibration; loss of lock relaunches when enabled and kickoff is clear
    wire kick_wr = ld_w2 & payload[W2_KICKOFF];
    wire relaunch = w1_q[W1_RETUNE_EN] & lock_fall & ~w2_q[W2_KICKOFF];
    // Completion clears kickoff, but a fresh kickoff write in the same cycle wins
    wire kick_d = kick_wr | relaunch | (w2_q[W2_KICKOFF] & ~cal_done & ~ld_w2);

    // ----------------------------------------
    // Next values of the words and pulses
    // ----------------------------------------
    // Unselected words hold, save the kickoff bit, so a load touches one word only
    wire [DATA_BITS-1:0] w1_d = ld_w1 ? payload : w1_q;
    wire [DATA_BITS-1:0] w3_d = ld_w3 ? payload : w3_q;
    wire [DATA_BITS-1:0] w2_ld = ld_w2 ? payload : w2_q;
    wire [DATA_BITS-1:0] w2_d = {w2_ld[DATA_BITS-1:W2_KICKOFF+1], kick_d, w2_ld[W2_KICKOFF-1:0]};
    wire start_d = kick_wr | relaunch;
    wire loaded_d = ld_any;

    // ----------------------------------------
    // Clocked state
    // ----------------------------------------
    // Edge history freezes with clk_en, so no false edge follows a pause
    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_q <= 1'b0;
            load_q <= 1'b0;
            locked_q <= 1'b0;
        end else if (clk_en) begin
            sclk_q <= sclk_s;
            load_q <= load_s;
            locked_q <= pll_locked;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_q <= '0;
        end else if (clk_en && shift_en) begin
            shift_q <= shift_d;
        end
    end

    // Power-down mode until first programming (reset value of third word)
    always_ff @(posedge clock) begin
        if (rst) begin
            w1_q <= DAC_MIXER_LO_WORD_RST;
            w2_q <= DIVIDER_PUMP_CAL_MUTE_WORD_RST;
            w3_q <= MODE_COUNTER_WORD_RST;
        end else if (clk_en) begin
            w1_q <= w1_d;
            w2_q <= w2_d;
            w3_q <= w3_d;
        end
    end

    // Pulses are registered so they line up with the word update
    always_ff @(posedge clock) begin
        if (rst) begin
            start_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (clk_en) begin
            start_q <= start_d;
            loaded_q <= loaded_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign dac_mixer_lo_word = w1_q;
    assign divider_pump_cal_mute_word = w2_q;
    assign mode_counter_word = w3_q;
    assign function_select = w3_q[W3_FUNC_HI:W3_FUNC_LO];
    assign retune_on_unlock_enable = w1_q[W1_RETUNE_EN];
    // Modulus is decoded from the stored bit, not kept as a register
    assign prescaler_modulus_value = w2_q[W2_PRESCALER] ? 5'(PRESCALER_HIGH) : 5'(PRESCALER_LOW);
    assign tuning_algorithm = w2_q[W2_ALGORITHM];
    assign tuning_kickoff = w2_q[W2_KICKOFF];
    assign cal_start = start_q;
    assign word_loaded = loaded_q;
endmodule : scw_port
`default_nettype wire

// *** scw_port_assertions.sv ***
// Checker: properties of the serial configuration write port
`timescale 1ns/1ps
`default_nettype none
module scw_port_assertions
    import scw_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Status
    input wire logic cal_done,
    input wire logic pll_locked,
    // Words and controls
    input wire logic [DATA_BITS-1:0] dac_mixer_lo_word,
    input wire logic [DATA_BITS-1:0] divider_pump_cal_mute_word,
    input wire logic [DATA_BITS-1:0] mode_counter_word,
    input wire logic [4:0] function_select,
    input wire logic retune_on_unlock_enable,
    input wire logic [4:0] prescaler_modulus_value,
    input wire logic tuning_algorithm,
    input wire logic tuning_kickoff,
    input wire logic cal_start,
    input wire logic word_loaded
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Lock loss relaunch sequences and all port properties
    // ----------------------------------------
    sequence s_unlock;
        clk_en && retune_on_unlock_enable && !tuning_kickoff && $fell(pll_locked);
    endsequence
    sequence s_relaunch;
        ##[1:2] cal_start;
    endsequence
    AST_RESET_CLEAR:
    assert property (disable iff (1'b0) rst && clk_en |=> !word_loaded && !cal_start &&
        (dac_mixer_lo_word | divider_pump_cal_mute_word | mode_counter_word) == 24'h000000) else $error("reset");
    AST_ONE_WORD:
    assert property (word_loaded && !$past(rst) |-> $countones({$changed(dac_mixer_lo_word),
        $changed(mode_counter_word), $changed(divider_pump_cal_mute_word[23:7])}) <= 1) else $error("two words");
    AST_NO_LOAD_STABLE:
    assert property (!word_loaded && !$past(rst) |-> $stable(dac_mixer_lo_word) && $stable(mode_counter_word))
        else $error("word moved");
    AST_PRESCALER:
    assert property (prescaler_modulus_value == (divider_pump_cal_mute_word[W2_PRESCALER] ? 5'h13 : 5'h10))
        else $error("prescaler");
    AST_FUNC:
    assert property (function_select == mode_counter_word[W3_FUNC_HI:W3_FUNC_LO]) else $error("func");
    AST_FIELDS:
    assert property (retune_on_unlock_enable == dac_mixer_lo_word[W1_RETUNE_EN] &&
        tuning_algorithm == divider_pump_cal_mute_word[W2_ALGORITHM]) else $error("fields");
    AST_KICK_START:
    assert property ($rose(tuning_kickoff) |-> cal_start) else $error("no start");
    AST_KICK_CLEAR:
    assert property (clk_en && tuning_kickoff && cal_done |=> !tuning_kickoff || word_loaded) else $error("kick");
    AST_KICK_HOLD:
    assert property (clk_en && tuning_kickoff && !cal_done |=> tuning_kickoff || word_loaded) else $error("kick");
    AST_RELAUNCH:
    assert property (s_unlock |-> s_relaunch) else $error("no relaunch");
endmodule : scw_port_assertions
bind scw_port scw_port_assertions chk (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .cal_done(cal_done),
    .pll_locked(pll_locked),
    .dac_mixer_lo_word(dac_mixer_lo_word),
    .divider_pump_cal_mute_word(divider_pump_cal_mute_word),
    .mode_counter_word(mode_counter_word),
    .function_select(function_select),
    .retune_on_unlock_enable(retune_on_unlock_enable),
    .prescaler_modulus_value(prescaler_modulus_value),
    .tuning_algorithm(tuning_algorithm),
    .tuning_kickoff(tuning_kickoff),
    .cal_start(cal_start),
    .word_loaded(word_loaded)
);
`default_nettype wire

// *** scw_port_tb_top.sv ***
// Testbench: scenarios for the serial configuration write port
`timescale 1ns/1ps
`default_nettype none
module scw_port_tb_top;
    import scw_pkg::*;
    // Stands for more than 1023 reference clock periods between loads
    localparam int REF_GAP = 1100;
    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1, host_bus_select = 1'b1, cal_done = 1'b0, pll_locked = 1'b1;
    logic serial_clk, serial_data, serial_load, retune_on_unlock_enable, tuning_algorithm, tuning_kickoff;
    logic [DATA_BITS-1:0] dac_mixer_lo_word, divider_pump_cal_mute_word, mode_counter_word;
    logic [4:0] function_select, prescaler_modulus_value;
    logic cal_start, word_loaded;
    int mismatches = 0, check_count = 0, cycles = 0, loads = 0, starts = 0, s;
    scw_port dut (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .host_bus_select(host_bus_select),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .serial_load(serial_load),
        .cal_done(cal_done),
        .pll_locked(pll_locked),
        .dac_mixer_lo_word(dac_mixer_lo_word),
        .divider_pump_cal_mute_word(divider_pump_cal_mute_word),
        .mode_counter_word(mode_counter_word),
        .function_select(function_select),
        .retune_on_unlock_enable(retune_on_unlock_enable),
        .prescaler_modulus_value(prescaler_modulus_value),
        .tuning_algorithm(tuning_algorithm),
        .tuning_kickoff(tuning_kickoff),
        .cal_start(cal_start),
        .word_loaded(word_loaded)
    );
    scw_host_model host (
        .clock(clock),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .serial_load(serial_load)
    );
    initial forever #5 clock = ~clock;
    // Pulses counted here; a hang ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        loads <= loads + int'(word_loaded === 1'b1);
        starts <= starts + int'(cal_start === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [1:0] sel, logic [23:0] d);
        host.send({4'h0, sel, d}, 26);
    endtask : wr
    task automatic t_words();
        s = loads;
        chk("mode", 24'h000000, mode_counter_word);
        wr(SEL_DAC_MIXER_LO_WORD, 24'hA5C3F4);
        chk("dac", 24'hA5C3F4, dac_mixer_lo_word);
        chk("retune", 24'h000001, 24'(retune_on_unlock_enable));
        wr(SEL_MODE_COUNTER_WORD, 24'h0E1234);
        chk("func", 24'h000007, 24'(function_select));
        chk("dac", 24'hA5C3F4, dac_mixer_lo_word);
        repeat (REF_GAP) @(posedge clock);
        wr(SEL_DIVIDER_PUMP_CAL_MUTE_WORD, 24'h3C1E80);
        chk("div", 24'h3C1E80, divider_pump_cal_mute_word);
        chk("presc", 24'h000010, 24'(prescaler_modulus_value));
        chk("algo", 24'h000001, 24'(tuning_algorithm));
        chk("loads", 24'(s + 3), 24'(loads));
        $display("test words done");
    endtask : t_words
    task automatic t_kick();
        s = starts;
        wr(SEL_DIVIDER_PUMP_CAL_MUTE_WORD, 24'h3C1F40);
        chk("kick", 24'h000001, 24'(tuning_kickoff));
        chk("presc", 24'h000013, 24'(prescaler_modulus_value));
        chk("starts", 24'(s + 1), 24'(starts));
        cal_done <= 1'b1;
        @(posedge clock);
        cal_done <= 1'b0;
        repeat (3) @(posedge clock);
        chk("div", 24'h3C1F00, divider_pump_cal_mute_word);
        wr(SEL_MODE_COUNTER_WORD, 24'h0E1234);
        wr(SEL_DIVIDER_PUMP_CAL_MUTE_WORD, 24'h3C1E80);
        chk("kick", 24'h000000, 24'(tuning_kickoff));
        chk("starts", 24'(s + 1), 24'(starts));
        $display("test kick done");
    endtask : t_kick
    task automatic t_refuse();
        s = loads;
        wr(SEL_RESERVED_WORD, 24'hFFFFFF);
        host_bus_select <= 1'b0;
        wr(SEL_DAC_MIXER_LO_WORD, 24'h000000);
        host_bus_select <= 1'b1;
        chk("loads", 24'(s), 24'(loads));
        chk("dac", 24'hA5C3F4, dac_mixer_lo_word);
        host.send({4'hA, SEL_MODE_COUNTER_WORD, 24'h020001}, 30);
        chk("mode", 24'h020001, mode_counter_word);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_unlock();
        s = starts;
        wr(SEL_DAC_MIXER_LO_WORD, 24'hA5C2F4);
        chk("retune", 24'h000000, 24'(retune_on_unlock_enable));
        pll_locked <= 1'b0;
        repeat (6) @(posedge clock);
        pll_locked <= 1'b1;
        chk("starts", 24'(s), 24'(starts));
        wr(SEL_DAC_MIXER_LO_WORD, 24'hA5C3F4);
        pll_locked <= 1'b0;
        repeat (6) @(posedge clock);
        pll_locked <= 1'b1;
        chk("starts", 24'(s + 1), 24'(starts));
        chk("kick", 24'h000001, 24'(tuning_kickoff));
        clk_en <= 1'b0;
        cal_done <= 1'b1;
        repeat (3) @(posedge clock);
        clk_en <= 1'b1;
        cal_done <= 1'b0;
        @(posedge clock);
        chk("frozen", 24'h000001, 24'(tuning_kickoff));
        cal_done <= 1'b1;
        @(posedge clock);
        cal_done <= 1'b0;
        repeat (2) @(posedge clock);
        chk("kick", 24'h000000, 24'(tuning_kickoff));
        $display("test unlock done");
    endtask : t_unlock
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_words();
        t_kick();
        t_refuse();
        t_unlock();
        test_done();
    end
endmodule : scw_port_tb_top
`default_nettype wire

// *** scw_sync.sv ***
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module scw_sync
    import scw_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Pin in, clean level out
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    wire agree = (s2_q == s3_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
endmodule : scw_sync
`default_nettype wire
